// [logic/usb_bus_ctl.sv]
// Bus signalling control and interrupt status of a USB controller
//
// Operation
// - Host cancel request drops an endpoint's scheduled IN if not yet issued.
// - Host may request a status IN on endpoint zero only.
// - Received status packet for that request raises an interrupt flag.
// - Host drives bus reset while requested; software holds it 20 ms or more.
// - Device drives resume while requested; software holds it 10 to 15 ms.
// - Host drives resume while requested; withdrawal finishes the resume sequence.
// - Host reports device speed: low, full, high or unknown.
// - Host suspend request stops bus traffic toward devices.
// - Each control interrupt source has its own enable.
// - Each endpoint interrupt source has its own separate enable.
// - Control and endpoint status are read through separate registers.
// - Reading control status clears the control flags that the read returns.
// - Reading endpoint status clears the endpoint flags that the read returns.
// - Host flags supply, attach, detach, fault; any mode flags frame, wakeup.
// - Host flags a device signalling past the end of a frame.
// - Device flags session end, reset, sleep; dual mode session start, role.
// - Endpoint status holds host and device groups covering every endpoint.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module usb_bus_ctl #(
   parameter int NEP = usb_ctl_pkg::NUM_EP
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [usb_ctl_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [usb_ctl_pkg::DATA_W-1:0] pwdata_i,
   output logic [usb_ctl_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [usb_ctl_pkg::CTL_IRQ_W-1:0] ctl_evt_i,
   input wire logic [NEP-1:0] ep_evt_host_i,
   input wire logic [NEP-1:0] ep_evt_dev_i,
   input wire logic [NEP-1:0] in_issued_i,
   input wire logic status_rcvd_i,
   input wire logic dev_attached_i,
   input wire logic [1:0] dev_speed_i,
   output logic [NEP-1:0] in_pending_o,
   output logic status_in_req_o,
   output logic bus_reset_o,
   output logic resume_drive_o,
   output logic resume_end_o,
   output logic suspend_o,
   output logic traffic_en_o,
   output logic [1:0] speed_o,
   output logic irq_o
);
   localparam int CW = usb_ctl_pkg::CTL_IRQ_W;
   localparam int EW = 2 * NEP;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic access;
   logic done;
   logic wr;
   logic rd;
   logic hit;
   logic [31:0] rd_mux;
   logic [1:0] mode_reg;
   logic reset_req_reg;
   logic resume_req_reg;
   logic suspend_req_reg;
   logic resume_q_reg;
   logic host_cap;
   logic dev_cap;
   logic dual_cap;
   logic [NEP-1:0] in_pend_reg;
   usb_ctl_pkg::sts_state_t sts_state_reg;
   logic status_req_reg;
   logic bus_reset_reg;
   logic resume_drive_reg;
   logic resume_end_reg;
   logic suspend_reg;
   logic traffic_en_reg;
   logic [1:0] speed_reg;
   logic irq_reg;
   logic [CW-1:0] ctl_ien_reg;
   logic [EW-1:0] ep_ien_reg;
   logic [CW-1:0] ctl_set;
   logic [CW-1:0] ctl_clr;
   logic [CW-1:0] ctl_flags;
   logic [EW-1:0] ep_set;
   logic [EW-1:0] ep_clr;
   logic [EW-1:0] ep_flags;
   logic [CW-1:0] ctl_mode_mask;
   logic sts_done;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, answer on second access cycle
   assign access = psel_i & penable_i;
   assign done = access & pready_reg;
   assign wr = done & pwrite_i;
   assign rd = done & ~pwrite_i;

   always_comb begin
      hit = 1'b1;
      rd_mux = '0;
      case (paddr_i)
         usb_ctl_pkg::OFF_CTRL: begin
            rd_mux[usb_ctl_pkg::CTRL_MODE_MSB:usb_ctl_pkg::CTRL_MODE_LSB] = mode_reg;
            rd_mux[usb_ctl_pkg::CTRL_RESET_BIT] = reset_req_reg;
            rd_mux[usb_ctl_pkg::CTRL_RESUME_BIT] = resume_req_reg;
            rd_mux[usb_ctl_pkg::CTRL_SUSPEND_BIT] = suspend_req_reg;
         end
         usb_ctl_pkg::OFF_CMD: begin
            rd_mux = '0;
         end
         usb_ctl_pkg::OFF_IN_REQ: begin
            rd_mux[NEP-1:0] = in_pend_reg;
         end
         usb_ctl_pkg::OFF_IN_CANCEL: begin
            rd_mux = '0;
         end
         usb_ctl_pkg::OFF_STAT: begin
            rd_mux[usb_ctl_pkg::STAT_SPEED_MSB:usb_ctl_pkg::STAT_SPEED_LSB] = speed_reg;
            rd_mux[usb_ctl_pkg::STAT_STS_PEND_BIT] = status_req_reg;
            rd_mux[usb_ctl_pkg::STAT_ATTACHED_BIT] = dev_attached_i;
         end
         usb_ctl_pkg::OFF_CTL_IEN: begin
            rd_mux[CW-1:0] = ctl_ien_reg;
         end
         usb_ctl_pkg::OFF_CTL_IST: begin
            rd_mux[CW-1:0] = ctl_flags;
         end
         usb_ctl_pkg::OFF_EP_IEN: begin
            rd_mux[EW-1:0] = ep_ien_reg;
         end
         usb_ctl_pkg::OFF_EP_IST: begin
            rd_mux[EW-1:0] = ep_flags;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= '0;
      end else begin
         pready_reg <= access & ~pready_reg;
         if (access && !pready_reg) begin
            pslverr_reg <= ~hit;
            prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
         end else if (done) begin
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register and mode qualifiers
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_reg <= usb_ctl_pkg::CTRL_RESET_VAL[1:0];
         reset_req_reg <= 1'b0;
         resume_req_reg <= 1'b0;
         suspend_req_reg <= 1'b0;
      end else if (wr && paddr_i == usb_ctl_pkg::OFF_CTRL) begin
         mode_reg <= pwdata_i[usb_ctl_pkg::CTRL_MODE_MSB:usb_ctl_pkg::CTRL_MODE_LSB];
         reset_req_reg <= pwdata_i[usb_ctl_pkg::CTRL_RESET_BIT];
         resume_req_reg <= pwdata_i[usb_ctl_pkg::CTRL_RESUME_BIT];
         suspend_req_reg <= pwdata_i[usb_ctl_pkg::CTRL_SUSPEND_BIT];
      end
   end

   assign dual_cap = mode_reg == usb_ctl_pkg::MODE_DUAL;
   assign host_cap = (mode_reg == usb_ctl_pkg::MODE_HOST) | dual_cap;
   assign dev_cap = (mode_reg == usb_ctl_pkg::MODE_DEVICE) | dual_cap;

   ////////////////////////////////////////////////////////////////////////////
   // Bus signalling outputs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_reset_reg <= 1'b0;
         resume_drive_reg <= 1'b0;
         resume_end_reg <= 1'b0;
         resume_q_reg <= 1'b0;
         suspend_reg <= 1'b0;
         traffic_en_reg <= 1'b0;
      end else begin
         bus_reset_reg <= host_cap & reset_req_reg;
         resume_drive_reg <= resume_req_reg;
         resume_q_reg <= resume_req_reg;
         resume_end_reg <= host_cap & resume_q_reg & ~resume_req_reg;
         suspend_reg <= host_cap & suspend_req_reg;
         traffic_en_reg <= host_cap & ~suspend_req_reg & ~reset_req_reg & ~resume_req_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Device speed report
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         speed_reg <= usb_ctl_pkg::speed_unknown;
      end else begin
         if (host_cap && dev_attached_i) begin
            speed_reg <= dev_speed_i;
         end else begin
            speed_reg <= usb_ctl_pkg::speed_unknown;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scheduled IN requests
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_pend_reg <= '0;
      end else if (!host_cap) begin
         in_pend_reg <= '0;
      end else if (wr && paddr_i == usb_ctl_pkg::OFF_IN_REQ) begin
         in_pend_reg <= (in_pend_reg & ~in_issued_i) | pwdata_i[NEP-1:0];
      end else if (wr && paddr_i == usb_ctl_pkg::OFF_IN_CANCEL) begin
         in_pend_reg <= in_pend_reg & ~in_issued_i & ~pwdata_i[NEP-1:0];
      end else begin
         in_pend_reg <= in_pend_reg & ~in_issued_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Endpoint zero status IN request
   assign sts_done = (sts_state_reg == usb_ctl_pkg::STS_WAIT) & status_rcvd_i;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sts_state_reg <= usb_ctl_pkg::STS_IDLE;
         status_req_reg <= 1'b0;
      end else begin
         case (sts_state_reg)
            usb_ctl_pkg::STS_IDLE: begin
               if (host_cap && wr && paddr_i == usb_ctl_pkg::OFF_CMD &&
                   pwdata_i[usb_ctl_pkg::CMD_STATUS_IN_BIT]) begin
                  sts_state_reg <= usb_ctl_pkg::STS_WAIT;
                  status_req_reg <= 1'b1;
               end
            end
            usb_ctl_pkg::STS_WAIT: begin
               if (status_rcvd_i || !host_cap) begin
                  sts_state_reg <= usb_ctl_pkg::STS_IDLE;
                  status_req_reg <= 1'b0;
               end
            end
            default: begin
               sts_state_reg <= usb_ctl_pkg::STS_IDLE;
               status_req_reg <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt enables
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctl_ien_reg <= '0;
      end else if (wr && paddr_i == usb_ctl_pkg::OFF_CTL_IEN) begin
         ctl_ien_reg <= pwdata_i[CW-1:0];
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ep_ien_reg <= '0;
      end else if (wr && paddr_i == usb_ctl_pkg::OFF_EP_IEN) begin
         ep_ien_reg <= pwdata_i[EW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status
   always_comb begin
      ctl_mode_mask = usb_ctl_pkg::CTL_ANY_MASK;
      if (host_cap) begin
         ctl_mode_mask = ctl_mode_mask | usb_ctl_pkg::CTL_HOST_MASK;
      end
      if (dev_cap) begin
         ctl_mode_mask = ctl_mode_mask | usb_ctl_pkg::CTL_DEV_MASK;
      end
      if (dual_cap) begin
         ctl_mode_mask = ctl_mode_mask | usb_ctl_pkg::CTL_DUAL_MASK;
      end
   end

   assign ctl_set = ctl_evt_i & ctl_mode_mask;
   assign ctl_clr = (rd && paddr_i == usb_ctl_pkg::OFF_CTL_IST) ?
                    prdata_reg[CW-1:0] : '0;

   always_comb begin
      ep_set = '0;
      if (host_cap) begin
         ep_set[NEP-1:0] = ep_evt_host_i;
      end
      if (dev_cap) begin
         ep_set[EW-1:NEP] = ep_evt_dev_i;
      end
      ep_set[0] = ep_set[0] | sts_done;
   end

   assign ep_clr = (rd && paddr_i == usb_ctl_pkg::OFF_EP_IST) ?
                   prdata_reg[EW-1:0] : '0;

   flag_bank #(.WIDTH(CW)) u_ctl_flags (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .set_i(ctl_set),
      .clr_i(ctl_clr),
      .flags_o(ctl_flags)
   );

   flag_bank #(.WIDTH(EW)) u_ep_flags (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .set_i(ep_set),
      .clr_i(ep_clr),
      .flags_o(ep_flags)
   );

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(ctl_flags & ctl_ien_reg) | |(ep_flags & ep_ien_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata_o = prdata_reg;
   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign in_pending_o = in_pend_reg;
   assign status_in_req_o = status_req_reg;
   assign bus_reset_o = bus_reset_reg;
   assign resume_drive_o = resume_drive_reg;
   assign resume_end_o = resume_end_reg;
   assign suspend_o = suspend_reg;
   assign traffic_en_o = traffic_en_reg;
   assign speed_o = speed_reg;
   assign irq_o = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_cancel;
      wr && paddr_i == usb_ctl_pkg::OFF_IN_CANCEL && host_cap;
   endsequence

   sequence s_sts_issue;
      host_cap && wr && paddr_i == usb_ctl_pkg::OFF_CMD &&
      pwdata_i[usb_ctl_pkg::CMD_STATUS_IN_BIT] && !status_req_reg;
   endsequence

   sequence s_ctl_read;
      rd && paddr_i == usb_ctl_pkg::OFF_CTL_IST;
   endsequence

   AST_CANCEL_IN: assert property (
      s_cancel |=> ((in_pend_reg & $past(pwdata_i[NEP-1:0])) == '0))
      else $error("cancelled IN request still pending");

   AST_STATUS_REQ: assert property (
      s_sts_issue |=> (status_in_req_o until (sts_done || !host_cap)))
      else $error("status IN request not held");

   AST_STATUS_IRQ: assert property (
      sts_done |=> ep_flags[0] ##1 !status_in_req_o[*1])
      else $error("status packet did not flag endpoint zero");

   AST_BUS_RESET: assert property (
      (host_cap && reset_req_reg) |=> bus_reset_o)
      else $error("bus reset not driven while requested");

   AST_RESUME_END: assert property (
      (host_cap && $fell(resume_req_reg)) |=> resume_end_o ##1 !resume_end_o)
      else $error("resume end pulse missing");

   AST_SPEED: assert property (
      !host_cap |=> speed_o == usb_ctl_pkg::speed_unknown)
      else $error("speed reported outside host mode");

   AST_SUSPEND: assert property (
      (host_cap && suspend_req_reg) |=> (suspend_o && !traffic_en_o))
      else $error("traffic not stopped in suspend");

   AST_CTL_CLEAR: assert property (
      (s_ctl_read ##0 (ctl_set == '0)) |=>
         ((ctl_flags & $past(prdata_reg[CW-1:0])) == '0))
      else $error("control status not cleared by read");

   AST_SET_WINS: assert property (
      (s_ctl_read ##0 ctl_set[usb_ctl_pkg::ctl_irq_frame_start]) |=>
         ctl_flags[usb_ctl_pkg::ctl_irq_frame_start])
      else $error("event lost during clearing read");

   AST_IRQ_MASK: assert property (
      ((ctl_flags & ctl_ien_reg) == '0 && (ep_flags & ep_ien_reg) == '0) |=> !irq_o)
      else $error("interrupt without enabled pending flag");

   AST_HOST_ONLY: assert property (
      (mode_reg == usb_ctl_pkg::MODE_DEVICE) |->
         (ctl_set & usb_ctl_pkg::CTL_HOST_MASK) == '0)
      else $error("host-only source set in device mode");
endmodule

// [logic/usb_ctl_pkg.sv]
// Register map, field layout and encodings of the bus control block
package usb_ctl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CTL_IRQ_W = 12;
   localparam int NUM_EP = 16;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_IN_REQ = 8'h08;
   localparam logic [7:0] OFF_IN_CANCEL = 8'h0c;
   localparam logic [7:0] OFF_STAT = 8'h10;
   localparam logic [7:0] OFF_CTL_IEN = 8'h14;
   localparam logic [7:0] OFF_CTL_IST = 8'h18;
   localparam logic [7:0] OFF_EP_IEN = 8'h1c;
   localparam logic [7:0] OFF_EP_IST = 8'h20;
   // Control and command register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MODE_MSB = 1;
   localparam int CTRL_RESET_BIT = 2;
   localparam int CTRL_RESUME_BIT = 3;
   localparam int CTRL_SUSPEND_BIT = 4;
   localparam int CMD_STATUS_IN_BIT = 0;
   // Status register fields
   localparam int STAT_SPEED_LSB = 0;
   localparam int STAT_SPEED_MSB = 1;
   localparam int STAT_STS_PEND_BIT = 2;
   localparam int STAT_ATTACHED_BIT = 3;
   // Control interrupt bit positions
   localparam int ctl_irq_supply_error = 0;
   localparam int ctl_irq_session_start = 1;
   localparam int ctl_irq_session_end = 2;
   localparam int ctl_irq_detach = 3;
   localparam int ctl_irq_attach = 4;
   localparam int ctl_irq_frame_start = 5;
   localparam int ctl_irq_overrun_frame = 6;
   localparam int ctl_irq_bus_reset_seen = 7;
   localparam int ctl_irq_wakeup_seen = 8;
   localparam int ctl_irq_sleep_seen = 9;
   localparam int ctl_irq_role_detected = 10;
   localparam int ctl_irq_supply_fault = 11;
   // Which control sources each mode may raise
   localparam logic [11:0] CTL_HOST_MASK = 12'h859;
   localparam logic [11:0] CTL_DEV_MASK = 12'h284;
   localparam logic [11:0] CTL_DUAL_MASK = 12'h402;
   localparam logic [11:0] CTL_ANY_MASK = 12'h120;
   localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
   typedef enum logic [1:0] {
      MODE_DEVICE = 2'b00,
      MODE_HOST = 2'b01,
      MODE_DUAL = 2'b10
   } mode_t;
   typedef enum logic [1:0] {
      speed_unknown = 2'b00,
      SPEED_LOW = 2'b01,
      SPEED_FULL = 2'b10,
      SPEED_HIGH = 2'b11
   } speed_t;
   typedef enum logic [0:0] {
      STS_IDLE = 1'b0,
      STS_WAIT = 1'b1
   } sts_state_t;
endpackage

// [logic/flag_bank.sv]
// Sticky event flags with masked clear where a new set wins
`timescale 1ns/10ps
module flag_bank #(
   parameter int WIDTH = 12
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clr_i,
   output logic [WIDTH-1:0] flags_o
);
   logic [WIDTH-1:0] flags_reg;
   logic [WIDTH-1:0] flags_next;

   always_comb begin
      flags_next = (flags_reg & ~clr_i) | set_i;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign flags_o = flags_reg;
endmodule

// [verification/usb_far_end.sv]
// Far-side USB device model answering status and IN requests
`timescale 1ns/10ps
module usb_far_end (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic status_req_i,
   input wire logic [15:0] in_pend_i,
   input wire logic traffic_i,
   input wire logic issue_en_i,
   input wire logic [3:0] delay_i,
   input wire logic attach_i,
   input wire logic [1:0] speed_i,
   output logic status_rcvd_o,
   output logic [15:0] in_issued_o,
   output logic attached_o,
   output logic [1:0] speed_o
);
   logic [3:0] wait_reg;
   ////////////////////////////////////////////////////////////////
   // status answer, only while traffic runs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status_rcvd_o <= 1'b0;
         wait_reg <= 4'h0;
      end else begin
         status_rcvd_o <= 1'b0;
         if (status_req_i && traffic_i && !status_rcvd_o) begin
            if (wait_reg == delay_i) begin
               status_rcvd_o <= 1'b1;
               wait_reg <= 4'h0;
            end else begin
               wait_reg <= wait_reg + 4'h1;
            end
         end
      end
   end
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_issued_o <= 16'h0000;
      end else begin
         in_issued_o <= (issue_en_i && traffic_i) ? (in_pend_i & ~in_issued_o) : 16'h0000;
      end
   end
   assign attached_o = attach_i;
   assign speed_o = attach_i ? speed_i : 2'b00;
endmodule

// [verification/tb.sv]
// Self-checking bench of the bus control block
`timescale 1ns/10ps
module tb;
   logic ref_clk_i, arst_n_i, psel_i, penable_i, pwrite_i;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic pready_o, pslverr_o, status_rcvd_i, dev_attached_i, status_in_req_o, bus_reset_o;
   logic [11:0] ctl_evt_i;
   logic [15:0] ep_evt_host_i, ep_evt_dev_i, in_issued_i, in_pending_o;
   logic [1:0] dev_speed_i, speed_o, speed_set;
   logic resume_drive_o, resume_end_o, suspend_o, traffic_en_o, irq_o, issue_en, attach;
   int err_total, n_compared;
   usb_bus_ctl usb_bus_ctl_i (.ref_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .ctl_evt_i, .ep_evt_host_i, .ep_evt_dev_i,
      .in_issued_i, .status_rcvd_i, .dev_attached_i, .dev_speed_i, .in_pending_o,
      .status_in_req_o, .bus_reset_o, .resume_drive_o, .resume_end_o, .suspend_o,
      .traffic_en_o, .speed_o, .irq_o);
   usb_far_end usb_far_end_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
      .status_req_i(status_in_req_o), .in_pend_i(in_pending_o), .traffic_i(traffic_en_o),
      .issue_en_i(issue_en), .delay_i(4'h3), .attach_i(attach), .speed_i(speed_set),
      .status_rcvd_o(status_rcvd_i), .in_issued_o(in_issued_i),
      .attached_o(dev_attached_i), .speed_o(dev_speed_i));
   always #2 ref_clk_i = ~ref_clk_i;
   ////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) err_total++;
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(nm, r, exp);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      check("traffic", traffic_en_o, 32'h0);
      rdc(usb_ctl_pkg::OFF_STAT, 32'h0, "stat");
      apb(1'b0, 8'h40, 32'h0, r, e);
      check("unmapped", {e, r[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_irq_ctl();
      logic [11:0] m[3];
      m = '{usb_ctl_pkg::CTL_DEV_MASK | usb_ctl_pkg::CTL_ANY_MASK,
            usb_ctl_pkg::CTL_HOST_MASK | usb_ctl_pkg::CTL_ANY_MASK, 12'hfff};
      for (int i = 0; i < 3; i++) begin
         wr(usb_ctl_pkg::OFF_CTRL, 32'(i));
         wr(usb_ctl_pkg::OFF_CTL_IEN, (i == 0) ? 32'h0 : 32'hfff);
         ctl_evt_i <= 12'hfff;
         @(posedge ref_clk_i);
         ctl_evt_i <= 12'h000;
         tick(3);
         check("irq_ctl", irq_o, 32'(i != 0));
         rdc(usb_ctl_pkg::OFF_CTL_IST, 32'(m[i]), "ctl_ist");
         rdc(usb_ctl_pkg::OFF_CTL_IST, 32'h0, "ctl_clr");
         tick(2);
         check("irq_off", irq_o, 32'h0);
      end
   endtask
   task automatic t_irq_ep();
      logic [31:0] r1, r2;
      logic e;
      wr(usb_ctl_pkg::OFF_EP_IEN, 32'h0100_0000);
      ep_evt_host_i <= 16'h8001;
      ep_evt_dev_i <= 16'h0100;
      @(posedge ref_clk_i);
      ep_evt_host_i <= 16'h0;
      ep_evt_dev_i <= 16'h0;
      tick(3);
      check("irq_ep", irq_o, 32'h1);
      rdc(usb_ctl_pkg::OFF_CTL_IST, 32'h0, "ctl_apart");
      rdc(usb_ctl_pkg::OFF_EP_IST, 32'h0100_8001, "ep_ist");
      rdc(usb_ctl_pkg::OFF_EP_IST, 32'h0, "ep_clr");
      ep_evt_host_i <= 16'h0004;
      @(posedge ref_clk_i);
      ep_evt_host_i <= 16'h0;
      tick(3);
      check("irq_mask", irq_o, 32'h0);
      fork
         apb(1'b0, usb_ctl_pkg::OFF_EP_IST, 32'h0, r1, e);
         begin
            repeat (3) @(posedge ref_clk_i);
            ep_evt_host_i <= 16'h0006;
            @(posedge ref_clk_i);
            ep_evt_host_i <= 16'h0;
         end
      join
      apb(1'b0, usb_ctl_pkg::OFF_EP_IST, 32'h0, r2, e);
      check("ep_race_first", r1, 32'h4);
      check("ep_race_kept", r2, 32'h6);
   endtask
   task automatic t_in_cancel();
      wr(usb_ctl_pkg::OFF_IN_REQ, 32'h00f0);
      tick(1);
      check("in_req", in_pending_o, 32'h00f0);
      wr(usb_ctl_pkg::OFF_IN_CANCEL, 32'h0030);
      tick(1);
      check("in_cancel", in_pending_o, 32'h00c0);
      @(posedge ref_clk_i);
      issue_en <= 1'b1;
      tick(4);
      check("in_issued", in_pending_o, 32'h0);
      @(posedge ref_clk_i);
      issue_en <= 1'b0;
   endtask
   task automatic t_status();
      int n;
      wr(usb_ctl_pkg::OFF_CMD, 32'h1);
      tick(0);
      check("sts_req", status_in_req_o, 32'h1);
      n = 0;
      while (status_in_req_o !== 1'b0 && n < 40) begin
         tick(0);
         @(negedge ref_clk_i);
         n++;
      end
      tick(1);
      rdc(usb_ctl_pkg::OFF_EP_IST, 32'h1, "sts_done");
      wr(usb_ctl_pkg::OFF_CTRL, 32'h0);
      wr(usb_ctl_pkg::OFF_CMD, 32'h1);
      tick(2);
      check("sts_dev", status_in_req_o, 32'h0);
   endtask
   task automatic t_bus();
      int n;
      wr(usb_ctl_pkg::OFF_CTRL, 32'h8);
      tick(1);
      check("res_dev", resume_drive_o, 32'h1);
      wr(usb_ctl_pkg::OFF_CTRL, 32'h5);
      tick(1);
      check("reset", {bus_reset_o, traffic_en_o}, 32'h2);
      wr(usb_ctl_pkg::OFF_CTRL, 32'h9);
      tick(1);
      check("resume", {bus_reset_o, resume_drive_o}, 32'h1);
      wr(usb_ctl_pkg::OFF_CTRL, 32'h1);
      n = 0;
      while (resume_end_o !== 1'b1 && n < 6) begin
         tick(0);
         @(negedge ref_clk_i);
         n++;
      end
      check("res_end", 32'(n < 6), 32'h1);
      wr(usb_ctl_pkg::OFF_CTRL, 32'h11);
      tick(1);
      check("suspend", {suspend_o, traffic_en_o}, 32'h2);
   endtask
   task automatic t_speed();
      @(posedge ref_clk_i);
      attach <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         @(posedge ref_clk_i);
         speed_set <= 2'(s);
         tick(3);
         check("speed", speed_o, 32'(s));
      end
      wr(usb_ctl_pkg::OFF_CTRL, 32'h0);
      tick(3);
      check("speed_dev", speed_o, 32'h0);
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      err_total++;
      end_of_test();
   end
   initial begin
      {ref_clk_i, arst_n_i, psel_i, penable_i, pwrite_i, issue_en, attach} = '0;
      {paddr_i, pwdata_i, ctl_evt_i, ep_evt_host_i, ep_evt_dev_i, speed_set} = '0;
      err_total = 0;
      n_compared = 0;
      repeat (8) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      t_reset();
      t_irq_ctl();
      t_irq_ep();
      t_in_cancel();
      t_status();
      t_bus();
      t_speed();
      end_of_test();
   end
endmodule
